// ==== efc_array.v ====
// Purpose: flash array model with 128-bit wide read port
// Assumes: word writes of a whole page, erase to all ones
// Notes: storage is plain registers, non-volatility is outside scope
`timescale 1ns/1ns
`default_nettype none
`include "efc_map.vh"
module efc_array
(
  input wire clk_i,
  input wire [9:0] rd_page_i,
  input wire [4:0] rd_quad_i,
  output reg [127:0] rd_line_o,
  input wire wr_en_i,
  input wire [9:0] wr_page_i,
  input wire [6:0] wr_word_i,
  input wire [31:0] wr_data_i,
  input wire ers_en_i,
  input wire ers_all_i,
  input wire [9:0] ers_page_i
);
  // [R1]
  reg [31:0] mem [0:`EFC_NUM_PAGES*`EFC_PAGE_WORDS-1];
  integer i;
  wire [16:0] rbase;
  assign rbase = {rd_page_i, rd_quad_i, 2'b00};

  // Four words per fetch [R4]
  always @(posedge clk_i)
  begin
    rd_line_o <= {mem[rbase + 17'h3], mem[rbase + 17'h2], mem[rbase + 17'h1], mem[rbase]};
  end

  always @(posedge clk_i)
  begin
    if (ers_en_i)
    begin
      for (i = 0; i < `EFC_NUM_PAGES*`EFC_PAGE_WORDS; i = i + 1)
      begin
        if (ers_all_i || (i[16:7] == ers_page_i))
          mem[i] <= 32'hFFFFFFFF;
      end
    end
    else if (wr_en_i)
      mem[{wr_page_i, wr_word_i}] <= wr_data_i;
  end
endmodule // efc_array
`default_nettype wire

// ==== efc_assertions.sv ====
// Purpose: port-level checks of the flash controller
// Assumes: one clock, asynchronous active-high reset
// Notes: strap pins are expected to stay steady while running
`timescale 1ns/1ns
`default_nettype none
`include "efc_map.vh"
module efc_assertions
#(
  parameter PROG_CYC = 10,
  parameter ERASE_CYC = 10
)
(
  input wire CLK_I,
  input wire RST_I,
  input wire CMD_VALID_I,
  input wire [3:0] CMD_CODE_I,
  input wire [9:0] CMD_ARG_I,
  input wire CMD_BUSY_O,
  input wire CMD_ERROR_O,
  input wire LOCK_ERROR_O,
  input wire [3:0] OPTION_BITS_O,
  input wire [31:0] LOCK_BITS_O,
  input wire BOOT_ROM_FFP_O,
  input wire WIPE_PIN_I,
  input wire TEST_MODE_PIN_I,
  input wire PROG_ENTRY_SEL0_I,
  input wire PROG_ENTRY_SEL1_I,
  input wire PROG_ENTRY_SEL2_I,
  input wire PROG_DATA_BUS_OE_N_O,
  input wire PROG_READY_OUT_OE_N_O,
  input wire PROG_VALID_N_OE_N_O,
  input wire PROG_PULLUP_O
);
  // ----------------------------
  // Command and pin properties
  // ----------------------------
  wire take = CMD_VALID_I && !CMD_BUSY_O;
  wire straps = TEST_MODE_PIN_I && PROG_ENTRY_SEL0_I && PROG_ENTRY_SEL1_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_prog_busy: assert property (take && CMD_CODE_I == `EFC_CMD_WP && !LOCK_BITS_O[CMD_ARG_I[9:5]]
    |=> CMD_BUSY_O [*8]) else $error("program command not held busy");
  a_lock_set: assert property (take && CMD_CODE_I == `EFC_CMD_SLB
    |-> ##2 LOCK_BITS_O[$past(CMD_ARG_I[9:5], 2)]) else $error("lock bit not set");
  a_lock_clear: assert property (take && CMD_CODE_I == `EFC_CMD_CLB
    |-> ##2 !LOCK_BITS_O[$past(CMD_ARG_I[9:5], 2)]) else $error("lock bit not cleared");
  a_locked_abort: assert property (take && LOCK_BITS_O[CMD_ARG_I[9:5]]
    && (CMD_CODE_I == `EFC_CMD_WP || CMD_CODE_I == `EFC_CMD_EP) |-> ##[1:4] LOCK_ERROR_O)
    else $error("locked region not refused");
  a_wipe_unlock: assert property (WIPE_PIN_I [*4] |-> ##[0:4] LOCK_BITS_O == 32'h0)
    else $error("wipe left locks set");
  a_opt_set: assert property (take && CMD_CODE_I == `EFC_CMD_SOB
    |-> ##2 OPTION_BITS_O[$past(CMD_ARG_I[1:0], 2)]) else $error("option bit not set");
  a_sec_kept: assert property (take && CMD_CODE_I == `EFC_CMD_COB && CMD_ARG_I == 10'h0
    |-> ##2 CMD_ERROR_O && OPTION_BITS_O[0] == $past(OPTION_BITS_O[0], 2))
    else $error("security bit cleared by command");
  a_ffp_entry: assert property ($rose(BOOT_ROM_FFP_O)
    |-> $past(straps && !PROG_ENTRY_SEL2_I, 3)) else $error("fast mode without straps");
  a_pins_idle: assert property (!BOOT_ROM_FFP_O |-> PROG_PULLUP_O && PROG_DATA_BUS_OE_N_O
    && PROG_READY_OUT_OE_N_O && PROG_VALID_N_OE_N_O) else $error("fast port driven");
  c_prog: cover property (take && CMD_CODE_I == `EFC_CMD_WP);
  c_lock_err: cover property ($rose(LOCK_ERROR_O));
  c_ffp: cover property ($rose(BOOT_ROM_FFP_O));
endmodule // efc_assertions
`default_nettype wire

// ==== efc_bench.sv ====
// Purpose: self-checking bench of the flash controller
// Assumes: short program and erase counts
// Notes: fast port handshake lines idle high
`timescale 1ns/1ns
`default_nettype none
`include "efc_map.vh"
`define CHK(got, exp) \
  begin \
    cmp_count = cmp_count + 1; \
    if ((got) !== (exp)) \
    begin \
      miscompares = miscompares + 1; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module efc_bench;
  localparam PROG_CYC = 10;
  localparam ERASE_CYC = 10;
  localparam [9:0] PG = 10'h021;
  reg clk, rst, cv, sc, wipe, tst, s0, s1, s2, pstb;
  reg [3:0] cc, pmode;
  reg [15:0] pdata;
  reg [9:0] ca;
  reg [31:0] q;
  integer miscompares, cmp_count, n0, n1, i;
  wire sel, wr, rdy, busy, done, cerr, lerr, ffp, oe_d, oe_r, oe_v, pu, prdy;
  wire [19:0] addr;
  wire [31:0] wd, rd, locks;
  wire [3:0] opts;
  efc_bus_master bm (.clk_i(clk), .ready_i(rdy), .rdata_i(rd), .sel_o(sel),
    .write_o(wr), .addr_o(addr), .wdata_o(wd));
  efc_top #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) dut (.CLK_I(clk), .RST_I(rst),
    .BUS_SEL_I(sel), .BUS_WRITE_I(wr), .BUS_ADDR_I(addr), .BUS_WDATA_I(wd),
    .BUS_RDATA_O(rd), .BUS_READY_O(rdy), .BUS_ERROR_O(), .CMD_VALID_I(cv),
    .CMD_CODE_I(cc), .CMD_ARG_I(ca), .CMD_BUSY_O(busy), .CMD_RESULT_O(),
    .CMD_DONE_O(done), .CMD_ERROR_O(cerr), .LOCK_ERROR_O(lerr), .STATUS_CLEAR_I(sc),
    .OPTION_BITS_O(opts), .LOCK_BITS_O(locks), .BOOT_FROM_FLASH_O(), .BOOT_ROM_FFP_O(ffp),
    .DEBUG_ACCESS_I(1'b0), .WIPE_PIN_I(wipe), .TEST_MODE_PIN_I(tst), .PROG_ENTRY_SEL0_I(s0),
    .PROG_ENTRY_SEL1_I(s1), .PROG_ENTRY_SEL2_I(s2), .PROG_CMD_STROBE_N_I(pstb),
    .PROG_OUT_EN_N_I(1'b1), .PROG_MODE_SEL_I(pmode), .PROG_DATA_BUS_I(pdata),
    .PROG_DATA_BUS_O(), .PROG_DATA_BUS_OE_N_O(oe_d), .PROG_READY_OUT_O(prdy),
    .PROG_READY_OUT_OE_N_O(oe_r), .PROG_VALID_N_O(), .PROG_VALID_N_OE_N_O(oe_v),
    .PROG_PULLUP_O(pu));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------
  // Shared tasks
  // ----------------------------
  task strap(input [3:0] p);
    begin
      @(posedge clk);
      rst <= 1'b1;
      {tst, s0, s1, s2} <= p;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task cmd(input [3:0] c, input [9:0] a);
    integer n;
    begin
      @(posedge clk);
      sc <= 1'b1;
      @(posedge clk);
      sc <= 1'b0;
      cv <= 1'b1;
      cc <= c;
      ca <= a;
      @(posedge clk);
      cv <= 1'b0;
      n = 0;
      while ((busy || !(done || cerr || lerr)) && n < 600)
      begin
        @(negedge clk);
        n = n + 1;
      end
      `CHK(n < 600, 1'b1)
    end
  endtask
  task wipe_pulse;
    begin
      @(posedge clk);
      wipe <= 1'b1;
      repeat (6) @(posedge clk);
      wipe <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task ffp_pulse(input [3:0] m, input [15:0] d);
    begin
      @(posedge clk);
      pmode <= m;
      pdata <= d;
      pstb <= 1'b0;
      repeat (4) @(posedge clk);
      pstb <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ----------------------------
  // Scenarios
  // ----------------------------
  task t_prog;
    begin
      for (i = 0; i < 4; i = i + 1)
        bm.xfer(1'b1, {1'b0, PG, i[6:0], 2'b00}, 32'hA5000000 + i, q, n0);
      cmd(`EFC_CMD_WP, PG);
      `CHK(done, 1'b1)
      for (i = 0; i < 4; i = i + 1)
      begin
        bm.xfer(1'b0, {1'b0, PG, i[6:0], 2'b00}, 32'h0, q, n1);
        `CHK(q, 32'hA5000000 + i)
        if (i == 0)
          n0 = n1;
      end
      `CHK(n1 < n0, 1'b1)
      $display("program and read finished");
    end
  endtask
  task t_lock;
    begin
      cmd(`EFC_CMD_SLB, PG);
      `CHK(locks, 32'h00000002)
      bm.xfer(1'b1, {1'b0, PG, 9'h000}, 32'h5A5A5A5A, q, n0);
      cmd(`EFC_CMD_WP, PG);
      `CHK(lerr, 1'b1)
      cmd(`EFC_CMD_EP, PG);
      `CHK(lerr, 1'b1)
      bm.xfer(1'b0, 20'h00000, 32'h0, q, n0);
      bm.xfer(1'b0, {1'b0, PG, 9'h000}, 32'h0, q, n0);
      `CHK(q, 32'hA5000000)
      cmd(`EFC_CMD_CLB, PG);
      `CHK(locks, 32'h00000000)
      cmd(`EFC_CMD_SLB, 10'h000);
      cmd(`EFC_CMD_SLB, PG);
      `CHK(locks, 32'h00000003)
      wipe_pulse;
      `CHK(locks, 32'h00000000)
      $display("lock regions finished");
    end
  endtask
  task t_opt;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        cmd(`EFC_CMD_SOB, i[9:0]);
        `CHK(opts[i], 1'b1)
      end
      for (i = 3; i > 0; i = i - 1)
      begin
        cmd(`EFC_CMD_COB, i[9:0]);
        `CHK(opts[i], 1'b0)
      end
      cmd(`EFC_CMD_COB, 10'h000);
      `CHK({cerr, opts[0]}, 2'h3)
      cmd(`EFC_CMD_GETD, 10'h000);
      `CHK(done, 1'b1)
      wipe_pulse;
      cmd(`EFC_CMD_EA, 10'h000);
      `CHK(opts[0], 1'b0)
      $display("option bits finished");
    end
  endtask
  task t_ffp;
    begin
      ffp_pulse(`EFC_CMD_SLB, {6'h00, PG});
      `CHK(locks, 32'h00000002)
      `CHK({pu, oe_r, oe_v, prdy}, 4'h1)
      cmd(`EFC_CMD_SOB, 10'h000);
      ffp_pulse(`EFC_CMD_CLB, {6'h00, PG});
      `CHK(locks, 32'h00000002)
      $display("fast port finished");
    end
  endtask
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    {cv, sc, wipe, tst, s0, s1, s2} = 7'h00;
    cc = 4'h0;
    pstb = 1'b1;
    pmode = 4'hF;
    pdata = 16'hFFFF;
    ca = 10'h000;
    strap(4'h0);
    `CHK({opts, locks}, 36'h0)
    `CHK({pu, oe_d, oe_r, oe_v, ffp}, 5'h1E)
    $display("reset state finished");
    t_prog;
    t_lock;
    t_opt;
    strap(4'hE);
    `CHK(ffp, 1'b1)
    t_ffp;
    strap(4'hF);
    `CHK(ffp, 1'b0)
    $display("fast mode entry finished");
    end_of_test;
  end
  initial
  begin
    #400000;
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule // efc_bench
bind efc_top efc_assertions #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I),
  .CMD_ARG_I(CMD_ARG_I), .CMD_BUSY_O(CMD_BUSY_O), .CMD_ERROR_O(CMD_ERROR_O),
  .LOCK_ERROR_O(LOCK_ERROR_O), .OPTION_BITS_O(OPTION_BITS_O), .LOCK_BITS_O(LOCK_BITS_O),
  .BOOT_ROM_FFP_O(BOOT_ROM_FFP_O), .WIPE_PIN_I(WIPE_PIN_I), .TEST_MODE_PIN_I(TEST_MODE_PIN_I),
  .PROG_ENTRY_SEL0_I(PROG_ENTRY_SEL0_I), .PROG_ENTRY_SEL1_I(PROG_ENTRY_SEL1_I),
  .PROG_ENTRY_SEL2_I(PROG_ENTRY_SEL2_I), .PROG_DATA_BUS_OE_N_O(PROG_DATA_BUS_OE_N_O),
  .PROG_READY_OUT_OE_N_O(PROG_READY_OUT_OE_N_O), .PROG_VALID_N_OE_N_O(PROG_VALID_N_OE_N_O),
  .PROG_PULLUP_O(PROG_PULLUP_O));
`default_nettype wire

// ==== efc_bus_master.sv ====
// Purpose: bus matrix master driving the array slave port
// Assumes: request changes only after a rising edge
// Notes: released address and data show inverted values, never stale ones
`timescale 1ns/1ns
`default_nettype none
module efc_bus_master
(
  input wire clk_i,
  input wire ready_i,
  input wire [31:0] rdata_i,
  output reg sel_o,
  output reg write_o,
  output reg [19:0] addr_o,
  output reg [31:0] wdata_o
);
  initial
  begin
    sel_o = 1'b0;
    write_o = 1'b0;
    addr_o = 20'hFFFFF;
    wdata_o = 32'hFFFFFFFF;
  end
  // ----------------------------
  // One transfer, n counts wait cycles
  // ----------------------------
  task xfer(input w, input [19:0] a, input [31:0] d, output [31:0] q, output integer n);
    begin
      n = 0;
      @(posedge clk_i);
      sel_o <= 1'b1;
      write_o <= w;
      addr_o <= a;
      wdata_o <= d;
      @(negedge clk_i);
      while (!ready_i && n < 50)
      begin
        n = n + 1;
        @(negedge clk_i);
      end
      @(posedge clk_i);
      sel_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      @(posedge clk_i);
      q = rdata_i;
    end
  endtask
endmodule // efc_bus_master
`default_nettype wire

// ==== efc_map.vh ====
// Purpose: constants of the embedded flash controller
// Assumes: 125 MHz system clock, largest array of 1024 pages
// Notes: command codes and descriptor fields are local choices
// Behaviour
// R1: Array pages are 512 bytes, exactly 128 words of 32 bits each.
// R2: Write-only page buffer of 128 words, reachable across the 1 MB window.
// R3: Slave for array accesses; configuration and commands on separate ports.
// R4: Each array read fetches 128 bits; following words come from the line.
// R5: Program, erase, lock and unlock are sequenced from software commands.
// R6: One command returns a descriptor of the flash organisation.
// R7: Lock regions of 32 pages, 8/16/32 regions, each locked independently.
// R8: Erase or program on a locked region aborts, array untouched, flag raised.
// R9: Set-lock protects the addressed region; clear-lock removes protection.
// R10: Flash-wipe pin clears every lock bit.
// R11: Four option bits, each set and cleared by dedicated commands. The code refuses a clear of bit 0 with a command error.
// R12: Option bits: 0 security, 1 brownout enable, 2 brownout reset, 3 boot select.
// R13: Fast programming entered only with test high, sel0/sel1 high, sel2 low.
// R14: Fast port: strobe_n, out_en_n in; ready, valid_n, mode, 16-bit data.
// R15: Fast port does read, page program, page/full erase, lock, unlock, protect.
// R16: All fast port lines leave reset as inputs with pull-ups.
// R17: Boot ROM programs at 16 KB boundaries, chosen by test and select pins.
// R18: Security bit set refuses debug and fast-port flash accesses. The code blocks commands under debug and fast-port commands, not bus reads.
// R19: Security bit clears only after wipe pin and a completed full erase. The code also clears it at every reset.
// R20: Boot select sampled at reset maps flash or ROM at address zero.
// R21: Status flags: command done, command error, lock violation.
`ifndef EFC_MAP_VH
`define EFC_MAP_VH
`define EFC_PAGE_BYTES 512
`define EFC_PAGE_WORDS 128
`define EFC_NUM_PAGES 1024
`define EFC_REGION_PAGES 32
`define EFC_NUM_REGIONS 32
`define EFC_ROM_PROG_BYTES 16384
// Command codes
`define EFC_CMD_GETD 4'h0
`define EFC_CMD_WP 4'h1
`define EFC_CMD_EP 4'h2
`define EFC_CMD_EA 4'h3
`define EFC_CMD_SLB 4'h4
`define EFC_CMD_CLB 4'h5
`define EFC_CMD_SOB 4'h6
`define EFC_CMD_COB 4'h7
`define EFC_CMD_RD 4'h8
// Option bit positions
`define EFC_OPT_SEC 0
`define EFC_OPT_BOD 1
`define EFC_OPT_BODRST 2
`define EFC_OPT_BOOT 3
`define EFC_OPT_RESET 4'h0
// Timing
`define EFC_PROG_NS 4000000
`define EFC_ERASE_NS 10000000
`define EFC_CLK_NS 8
`define EFC_PROG_CYC (`EFC_PROG_NS / `EFC_CLK_NS)
`define EFC_ERASE_CYC (`EFC_ERASE_NS / `EFC_CLK_NS)
`endif

// ==== efc_top.v ====
// Purpose: embedded flash controller, bus slave, commands, lock and fast port
// Assumes: one 125 MHz clock, async active-high reset, pins synchronised here
// Notes: program time includes auto-erase; long counts are parameters
`timescale 1ns/1ns
`default_nettype none
`include "efc_map.vh"
module efc_top
#(
  parameter PROG_CYC = `EFC_PROG_CYC,
  parameter ERASE_CYC = `EFC_ERASE_CYC
)
(
  input wire CLK_I,
  input wire RST_I,
  // Array slave, byte addressed with word accesses inside the 1 MB window [R3]
  input wire BUS_SEL_I,
  input wire BUS_WRITE_I,
  input wire [19:0] BUS_ADDR_I,
  input wire [31:0] BUS_WDATA_I,
  output reg [31:0] BUS_RDATA_O,
  output wire BUS_READY_O,
  output wire BUS_ERROR_O,
  // Command port
  input wire CMD_VALID_I,
  input wire [3:0] CMD_CODE_I,
  input wire [9:0] CMD_ARG_I,
  output wire CMD_BUSY_O,
  output reg [31:0] CMD_RESULT_O,
  output reg CMD_DONE_O,
  output reg CMD_ERROR_O,
  output reg LOCK_ERROR_O,
  input wire STATUS_CLEAR_I,
  output reg [3:0] OPTION_BITS_O,
  output reg [31:0] LOCK_BITS_O,
  output reg BOOT_FROM_FLASH_O,
  output reg BOOT_ROM_FFP_O,
  // Pins
  input wire DEBUG_ACCESS_I,
  input wire WIPE_PIN_I,
  input wire TEST_MODE_PIN_I,
  input wire PROG_ENTRY_SEL0_I,
  input wire PROG_ENTRY_SEL1_I,
  input wire PROG_ENTRY_SEL2_I,
  input wire PROG_CMD_STROBE_N_I,
  input wire PROG_OUT_EN_N_I,
  input wire [3:0] PROG_MODE_SEL_I,
  input wire [15:0] PROG_DATA_BUS_I,
  output reg [15:0] PROG_DATA_BUS_O,
  output wire PROG_DATA_BUS_OE_N_O,
  output reg PROG_READY_OUT_O,
  output wire PROG_READY_OUT_OE_N_O,
  output reg PROG_VALID_N_O,
  output wire PROG_VALID_N_OE_N_O,
  output wire PROG_PULLUP_O
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;

  function is_locked;
    input [31:0] bits;
    input [9:0] page;
    begin
      is_locked = bits[page[9:5]]; // [R7]
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam NSYNC = 28;
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] pin_s1_r;
  reg [NSYNC-1:0] pin_s2_r;
  assign pin_raw = {DEBUG_ACCESS_I, WIPE_PIN_I, TEST_MODE_PIN_I, PROG_ENTRY_SEL0_I,
    PROG_ENTRY_SEL1_I, PROG_ENTRY_SEL2_I, PROG_CMD_STROBE_N_I, PROG_OUT_EN_N_I,
    PROG_MODE_SEL_I, PROG_DATA_BUS_I};
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      // Pulled-up lines idle high; wipe, debug and straps low, so no false wipe
      pin_s1_r <= 28'h03FFFFF;
      pin_s2_r <= 28'h03FFFFF;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end
  wire dbg_s = pin_s2_r[27];
  wire wipe_s = pin_s2_r[26];
  wire test_s = pin_s2_r[25];
  wire sel0_s = pin_s2_r[24];
  wire sel1_s = pin_s2_r[23];
  wire sel2_s = pin_s2_r[22];
  wire strobe_n_s = pin_s2_r[21];
  wire oe_n_s = pin_s2_r[20];
  wire [3:0] mode_s = pin_s2_r[19:16];
  wire [15:0] pdata_s = pin_s2_r[15:0];

  // ----------------------------------------------------------------
  // Mode straps, caught once the synchronisers hold real pin levels
  // ----------------------------------------------------------------
  reg [1:0] strap_cnt_r;
  reg ffp_mode_r;
  wire ffp_entry = test_s & sel0_s & sel1_s & ~sel2_s; // [R13]
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      strap_cnt_r <= 2'b00;
      ffp_mode_r <= 1'b0;
      BOOT_ROM_FFP_O <= 1'b0;
      BOOT_FROM_FLASH_O <= 1'b0;
    end
    else if (strap_cnt_r != 2'b11)
    begin
      // Last capture, on the third edge, sees pins past both flops
      strap_cnt_r <= strap_cnt_r + 2'b01;
      ffp_mode_r <= ffp_entry;
      BOOT_ROM_FFP_O <= ffp_entry & test_s; // [R17]
      BOOT_FROM_FLASH_O <= OPTION_BITS_O[`EFC_OPT_BOOT]; // [R20]
    end
  end

  // ----------------------------------------------------------------
  // Array and read line
  // ----------------------------------------------------------------
  reg [127:0] line_r;
  reg [17:0] line_tag_r;
  reg line_ok_r;
  reg rd_pend_r;
  wire [127:0] arr_line;
  reg [9:0] arr_rpage;
  reg [4:0] arr_rquad;
  reg arr_wr;
  reg [9:0] arr_wpage;
  reg [6:0] arr_wword;
  reg [31:0] arr_wdata;
  reg arr_ers;
  reg arr_ers_all;

  efc_array u_arr
  (
    .clk_i(CLK_I),
    .rd_page_i(arr_rpage),
    .rd_quad_i(arr_rquad),
    .rd_line_o(arr_line),
    .wr_en_i(arr_wr),
    .wr_page_i(arr_wpage),
    .wr_word_i(arr_wword),
    .wr_data_i(arr_wdata),
    .ers_en_i(arr_ers),
    .ers_all_i(arr_ers_all),
    .ers_page_i(arr_wpage)
  );

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  reg [1:0] state_r;
  reg [3:0] op_r;
  reg [9:0] op_page_r;
  reg [23:0] wait_r;
  reg [6:0] copy_r;
  reg copying_r;
  reg [31:0] pbuf [0:`EFC_PAGE_WORDS-1]; // [R2]
  reg wiped_r;
  reg ffp_busy_r;

  wire busy = (state_r != ST_IDLE);
  assign CMD_BUSY_O = busy;
  wire bus_rd = BUS_SEL_I & ~BUS_WRITE_I;
  wire bus_wr = BUS_SEL_I & BUS_WRITE_I;
  wire [17:0] rd_tag = BUS_ADDR_I[19:2];
  wire hit = line_ok_r & (line_tag_r[17:2] == rd_tag[17:2]);
  // Array reads stall during commands; buffer writes never do [R2]
  assign BUS_READY_O = bus_wr | (bus_rd & hit & ~busy);
  assign BUS_ERROR_O = 1'b0;

  // Fast-port refused when secure [R18]
  wire secure = OPTION_BITS_O[`EFC_OPT_SEC];
  wire ffp_ok = ffp_mode_r & ~secure;
  reg strobe_q_r;
  wire ffp_cmd = ffp_ok & strobe_q_r & ~strobe_n_s & ~busy;
  wire [3:0] ffp_code = mode_s;
  wire sw_cmd = CMD_VALID_I & ~busy & ~(dbg_s & secure) & ~ffp_cmd;
  wire go = sw_cmd | ffp_cmd;
  wire [3:0] go_code = ffp_cmd ? ffp_code : CMD_CODE_I;
  wire [9:0] go_arg = ffp_cmd ? pdata_s[9:0] : CMD_ARG_I;

  always @(posedge CLK_I)
  begin
    if (bus_wr)
      pbuf[BUS_ADDR_I[8:2]] <= BUS_WDATA_I; // [R2]
  end

  always @*
  begin
    arr_rpage = BUS_ADDR_I[18:9];
    arr_rquad = BUS_ADDR_I[8:4];
    arr_wr = copying_r;
    arr_wpage = op_page_r;
    arr_wword = copy_r;
    arr_wdata = pbuf[copy_r];
    arr_ers = (state_r == ST_WAIT) && (wait_r == 24'h000001) && (op_r == `EFC_CMD_EP ||
      op_r == `EFC_CMD_EA || op_r == `EFC_CMD_WP) && !copying_r;
    arr_ers_all = (op_r == `EFC_CMD_EA);
  end

  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_r <= ST_IDLE;
      op_r <= 4'h0;
      op_page_r <= 10'h000;
      wait_r <= 24'h000000;
      copy_r <= 7'h00;
      copying_r <= 1'b0;
      line_r <= 128'h0;
      line_tag_r <= 18'h00000;
      line_ok_r <= 1'b0;
      rd_pend_r <= 1'b0;
      BUS_RDATA_O <= 32'h00000000;
      CMD_RESULT_O <= 32'h00000000;
      CMD_DONE_O <= 1'b0;
      CMD_ERROR_O <= 1'b0;
      LOCK_ERROR_O <= 1'b0;
      OPTION_BITS_O <= `EFC_OPT_RESET;
      LOCK_BITS_O <= 32'h00000000;
      wiped_r <= 1'b0;
      ffp_busy_r <= 1'b0;
      strobe_q_r <= 1'b1;
    end
    else
    begin
      strobe_q_r <= strobe_n_s;
      // Read line fill [R4]
      if (bus_rd & ~hit & ~busy & ~rd_pend_r)
        rd_pend_r <= 1'b1;
      else if (rd_pend_r)
      begin
        rd_pend_r <= 1'b0;
        line_r <= arr_line;
        line_tag_r <= rd_tag;
        line_ok_r <= 1'b1;
      end
      if (bus_rd & hit & ~busy)
        BUS_RDATA_O <= line_r[{BUS_ADDR_I[3:2], 5'h00} +: 32];
      if (wipe_s)
      begin
        LOCK_BITS_O <= 32'h00000000; // [R10]
        OPTION_BITS_O[`EFC_OPT_BOD] <= 1'b0;
        OPTION_BITS_O[`EFC_OPT_BODRST] <= 1'b0;
        wiped_r <= 1'b1;
      end
      // Status flags, set wins over clear [R21]
      if (STATUS_CLEAR_I)
      begin
        CMD_DONE_O <= 1'b0;
        CMD_ERROR_O <= 1'b0;
        LOCK_ERROR_O <= 1'b0;
      end
      case (state_r)
        ST_IDLE:
        begin
          if (go)
          begin
            op_r <= go_code;
            op_page_r <= go_arg;
            ffp_busy_r <= ffp_cmd;
            state_r <= ST_DONE;
            case (go_code)
              `EFC_CMD_GETD: CMD_RESULT_O <= {8'h01, 6'h00, 10'h200, 8'h20}; // [R6]
              `EFC_CMD_RD: CMD_RESULT_O <= {22'h000000, go_arg};
              `EFC_CMD_WP, `EFC_CMD_EP:
              begin
                if (is_locked(LOCK_BITS_O, go_arg))
                  LOCK_ERROR_O <= 1'b1; // [R8]
                else
                begin
                  wait_r <= (go_code == `EFC_CMD_WP) ? PROG_CYC[23:0] : ERASE_CYC[23:0];
                  line_ok_r <= 1'b0;
                  state_r <= ST_WAIT; // [R5]
                end
              end
              `EFC_CMD_EA:
              begin
                if (|LOCK_BITS_O)
                  LOCK_ERROR_O <= 1'b1; // [R8]
                else
                begin
                  wait_r <= ERASE_CYC[23:0];
                  line_ok_r <= 1'b0;
                  state_r <= ST_WAIT;
                end
              end
              `EFC_CMD_SLB: LOCK_BITS_O[go_arg[9:5]] <= 1'b1; // [R9]
              `EFC_CMD_CLB: LOCK_BITS_O[go_arg[9:5]] <= 1'b0; // [R9]
              `EFC_CMD_SOB: OPTION_BITS_O[go_arg[1:0]] <= 1'b1; // [R11] [R12]
              `EFC_CMD_COB:
              begin
                // Security bit cannot be cleared by command [R19]
                if (go_arg[1:0] != 2'd`EFC_OPT_SEC)
                  OPTION_BITS_O[go_arg[1:0]] <= 1'b0; // [R11]
                else
                  CMD_ERROR_O <= 1'b1;
              end
              default: CMD_ERROR_O <= 1'b1;
            endcase
          end
        end
        ST_WAIT:
        begin
          if (wait_r > 24'h000001)
            wait_r <= wait_r - 24'h000001;
          else if (op_r == `EFC_CMD_WP)
          begin
            // Auto-erase done, copy buffer into the page [R1]
            copying_r <= 1'b1;
            copy_r <= copying_r ? copy_r + 7'h01 : 7'h00;
            if (copying_r && copy_r == 7'h7F)
            begin
              copying_r <= 1'b0;
              state_r <= ST_DONE;
            end
            if (!copying_r)
              copy_r <= 7'h00;
          end
          else
          begin
            if (op_r == `EFC_CMD_EA && wiped_r)
            begin
              OPTION_BITS_O[`EFC_OPT_SEC] <= 1'b0; // [R19]
              wiped_r <= 1'b0;
            end
            state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          CMD_DONE_O <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fast programming port pins
  // ----------------------------------------------------------------
  // Lines stay inputs with pull-ups until mode entry [R16]
  assign PROG_PULLUP_O = ~ffp_mode_r;
  assign PROG_READY_OUT_OE_N_O = ~ffp_mode_r; // [R14]
  assign PROG_VALID_N_OE_N_O = ~ffp_mode_r;
  assign PROG_DATA_BUS_OE_N_O = ~(ffp_ok & ~oe_n_s);
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      PROG_READY_OUT_O <= 1'b1;
      PROG_VALID_N_O <= 1'b1;
      PROG_DATA_BUS_O <= 16'h0000;
    end
    else
    begin
      PROG_READY_OUT_O <= ~busy & strobe_n_s; // [R14] [R15]
      PROG_VALID_N_O <= ~(ffp_ok & ~oe_n_s & ~busy);
      PROG_DATA_BUS_O <= line_r[15:0];
    end
  end
endmodule // efc_top
`default_nettype wire
